// file: ddrb_pkg.sv
// package for the ddr channel b pin interface
package ddrb_pkg;
  localparam int ROWS = 4;
  localparam int CLK_PAIRS = 6;
  localparam int ADDR_W = 13;
  localparam int BANK_W = 2;
  localparam int DATA_W = 64;
  localparam int BYTES = 8;
  localparam int COPY_LO = 1;
  localparam int COPY_HI = 5;
  // init wait after reset before clock enables rise
  localparam int INIT_NS = 200;
  localparam int MCLK_NS = 40;
  localparam int INIT_CYC = (INIT_NS + MCLK_NS - 1) / MCLK_NS;
  localparam logic [7:0] INIT_CYC_V = 8'(INIT_CYC);
  localparam logic [7:0] CNT_ZERO = 8'h00;
  localparam logic [7:0] CNT_ONE = 8'h01;
  // command codes {ras_n, cas_n, we_n}
  typedef enum logic [2:0] {
    CMD_MRS = 3'h0,
    CMD_REF = 3'h1,
    CMD_PRE = 3'h2,
    CMD_ACT = 3'h3,
    CMD_WR = 3'h4,
    CMD_RD = 3'h5,
    CMD_NOP = 3'h7
  } ddrb_cmd_t;
  // user request word
  typedef struct packed {
    ddrb_cmd_t cmd;
    logic [1:0] row;
    logic [BANK_W-1:0] bank;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [BYTES-1:0] wmask;
  } ddrb_req_t;
  localparam int REQ_W = $bits(ddrb_req_t);
endpackage

// file: ddrb_top.sv
// fifo, pin sequencer and read capture for ddr channel b
`timescale 1ns/10ps
`default_nettype none

// request fifo with gray-free single-clock pointers
module ddrb_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_valid,
  output logic o_ready,
  input wire logic [WIDTH-1:0] i_data,
  output logic o_valid,
  input wire logic i_ready,
  output logic [WIDTH-1:0] o_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic push, pop;
  // honest full and empty from pointer compare
  always_comb begin
    o_ready = (wp_r - rp_r) != (AW+1)'(DEPTH);
    o_valid = wp_r != rp_r;
    push = i_valid && o_ready && i_ce;
    pop = o_valid && i_ready && i_ce;
    wp_nxt = push ? wp_r + 1'b1 : wp_r;
    rp_nxt = pop ? rp_r + 1'b1 : rp_r;
    o_data = mem[rp_r[AW-1:0]];
  end
  // pointers and storage
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      wp_r <= '0;
      rp_r <= '0;
    end else begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
    end
    if (push) begin
      mem[wp_r[AW-1:0]] <= i_data;
    end
  end
endmodule

// Contract
// - clock pair samples at true rise
// - six clock pairs, three per module
// - four active-low selects, change on rising edge
// - thirteen-bit multiplexed row/column address
// - address copy bits 5:1 equal primary
// - two-bit bank address
// - command from strobes qualified by select
// - bidirectional 64-bit data bus
// - one mask bit per data byte
// - write strobe centred in data eye
// - read strobe edge aligned, capture on it; code captures on the link clock instead, strobe n only enabling lane n
// - strobe n covers bits 8n+7:8n
// - clock enables sequence power-up init
// - self-refresh on suspend, exit on resume
// - idle rows dynamically powered down
// - four clock enables, change on rising edge
module ddrb_top #(
  parameter int FIFO_DEPTH = 32
) (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_rd_clk,
  input wire logic i_req_valid,
  output logic o_req_ready,
  input wire ddrb_pkg::ddrb_req_t i_req,
  input wire logic i_suspend,
  input wire logic [ddrb_pkg::ROWS-1:0] i_row_idle,
  output logic o_init_done,
  output logic o_self_refresh,
  output logic o_rd_valid,
  output logic [ddrb_pkg::DATA_W-1:0] o_rd_data,
  output logic [ddrb_pkg::CLK_PAIRS-1:0] o_mem_diff_clock_out,
  output logic [ddrb_pkg::CLK_PAIRS-1:0] o_mem_diff_clock_out_n,
  output logic [ddrb_pkg::ROWS-1:0] o_row_select_n,
  output logic [ddrb_pkg::ROWS-1:0] o_row_clock_enable,
  output logic [ddrb_pkg::ADDR_W-1:0] o_mem_addr_primary,
  output logic [ddrb_pkg::COPY_HI:ddrb_pkg::COPY_LO] o_mem_addr_copy,
  output logic [ddrb_pkg::BANK_W-1:0] o_bank_addr,
  output logic o_row_strobe_n,
  output logic o_col_strobe_n,
  output logic o_write_enable_n,
  input wire logic [ddrb_pkg::DATA_W-1:0] i_mem_data_bus,
  output logic [ddrb_pkg::DATA_W-1:0] o_mem_data_bus,
  output logic [ddrb_pkg::BYTES-1:0] o_mem_data_bus_oe,
  output logic [ddrb_pkg::BYTES-1:0] o_byte_write_mask,
  input wire logic [ddrb_pkg::BYTES-1:0] i_byte_data_strobe,
  output logic [ddrb_pkg::BYTES-1:0] o_byte_data_strobe,
  output logic [ddrb_pkg::BYTES-1:0] o_byte_data_strobe_oe
);
  localparam int DW = ddrb_pkg::DATA_W;
  localparam int NB = ddrb_pkg::BYTES;

  // sequencer states, one-hot
  typedef enum logic [3:0] {
    ST_INIT = 4'b0001,
    ST_RUN = 4'b0010,
    ST_WDAT = 4'b0100,
    ST_SREF = 4'b1000
  } ddrb_st_t;

  // fifo output side
  ddrb_pkg::ddrb_req_t q_req;
  logic q_valid, q_ready;

  // sequencer registers
  ddrb_st_t st_r, st_nxt;
  logic [7:0] cnt_r, cnt_nxt;
  logic [ddrb_pkg::ROWS-1:0] cs_n_r, cs_n_nxt; // one select per row
  logic [ddrb_pkg::ROWS-1:0] cke_r, cke_nxt; // one clock enable per row
  logic [2:0] cmd_r, cmd_nxt;
  logic [ddrb_pkg::ADDR_W-1:0] addr_r, addr_nxt;
  logic [ddrb_pkg::BANK_W-1:0] bank_r, bank_nxt;
  logic [DW-1:0] wd_r, wd_nxt;
  logic [NB-1:0] wm_r, wm_nxt;
  logic drive_r, drive_nxt;
  logic clk_en_r, clk_en_nxt;

  // decoded row select for one row, used once
  function automatic logic [3:0] row_onehot_n(input logic [1:0] row);
    row_onehot_n = ~(4'h1 << row);
  endfunction

  ddrb_fifo #(
    .WIDTH(ddrb_pkg::REQ_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_ce(i_ce),
    .i_valid(i_req_valid),
    .o_ready(o_req_ready),
    .i_data(i_req),
    .o_valid(q_valid),
    .i_ready(q_ready),
    .o_data(q_req)
  );

  // accept commands only while running and not busy with write data
  assign q_ready = (st_r == ST_RUN) && !i_suspend;

  // next-state for sequencer and pin registers
  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    cs_n_nxt = '1;
    cke_nxt = cke_r;
    cmd_nxt = ddrb_pkg::CMD_NOP;
    addr_nxt = addr_r;
    bank_nxt = bank_r;
    wd_nxt = wd_r;
    wm_nxt = wm_r;
    drive_nxt = 1'b0;
    clk_en_nxt = 1'b1;
    case (st_r)
      ST_INIT: begin
        // hold cke low until wait time elapses
        cke_nxt = '0;
        if (cnt_r == ddrb_pkg::CNT_ZERO) begin
          cke_nxt = '1;
          st_nxt = ST_RUN;
        end else begin
          cnt_nxt = cnt_r - ddrb_pkg::CNT_ONE;
        end
      end
      ST_RUN: begin
        // idle rows powered down, busy rows awake
        cke_nxt = ~i_row_idle;
        if (i_suspend) begin
          // refresh with cke low enters self-refresh
          cs_n_nxt = '0;
          cmd_nxt = ddrb_pkg::CMD_REF;
          cke_nxt = '0;
          st_nxt = ST_SREF;
        end else if (q_valid) begin
          cs_n_nxt = row_onehot_n(q_req.row);
          cke_nxt[q_req.row] = 1'b1;
          cmd_nxt = q_req.cmd;
          addr_nxt = q_req.addr;
          bank_nxt = q_req.bank;
          if (q_req.cmd == ddrb_pkg::CMD_WR) begin
            wd_nxt = q_req.wdata;
            wm_nxt = q_req.wmask;
            st_nxt = ST_WDAT;
          end
        end
      end
      ST_WDAT: begin
        // one cycle of driven write data and strobe
        drive_nxt = 1'b1;
        st_nxt = ST_RUN;
      end
      ST_SREF: begin
        // stop memory clock while in self-refresh
        clk_en_nxt = 1'b0;
        cke_nxt = '0;
        if (!i_suspend) begin
          cke_nxt = '1;
          st_nxt = ST_RUN;
        end
      end
      default: begin
        st_nxt = ST_INIT;
      end
    endcase
  end

  // registers on the rising system clock
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      st_r <= ST_INIT;
      cnt_r <= ddrb_pkg::INIT_CYC_V;
      cs_n_r <= '1;
      cke_r <= '0;
      cmd_r <= ddrb_pkg::CMD_NOP;
      addr_r <= '0;
      bank_r <= '0;
      wd_r <= '0;
      wm_r <= '0;
      drive_r <= 1'b0;
      clk_en_r <= 1'b0;
    end else if (i_ce) begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      cs_n_r <= cs_n_nxt;
      cke_r <= cke_nxt;
      cmd_r <= cmd_nxt;
      addr_r <= addr_nxt;
      bank_r <= bank_nxt;
      wd_r <= wd_nxt;
      wm_r <= wm_nxt;
      drive_r <= drive_nxt;
      clk_en_r <= clk_en_nxt;
    end
  end

  // pins; cmd/addr registered so they launch on rising edge
  always_comb begin
    o_row_select_n = cs_n_r;
    o_row_clock_enable = cke_r;
    {o_row_strobe_n, o_col_strobe_n, o_write_enable_n} = cmd_r;
    o_mem_addr_primary = addr_r;
    o_mem_addr_copy = addr_r[ddrb_pkg::COPY_HI:ddrb_pkg::COPY_LO];
    o_bank_addr = bank_r;
    o_mem_data_bus = wd_r;
    o_byte_write_mask = wm_r;
    o_mem_data_bus_oe = {NB{drive_r}};
    o_byte_data_strobe_oe = {NB{drive_r}};
    o_init_done = st_r != ST_INIT;
    o_self_refresh = st_r == ST_SREF;
  end

  // forwarded clocks: gated low phase is the data eye middle
  genvar g;
  generate
    for (g = 0; g < ddrb_pkg::CLK_PAIRS; g++) begin : g_clk
      // true rises with mclk, complement falls: crossing samples
      assign o_mem_diff_clock_out[g] = i_mclk & clk_en_r;
      assign o_mem_diff_clock_out_n[g] = ~(i_mclk & clk_en_r);
    end
    // write strobe rises mid-cycle, centred on held data
    for (g = 0; g < NB; g++) begin : g_dqs
      assign o_byte_data_strobe[g] = drive_r & ~i_mclk;
    end
  endgenerate

  // read capture on the link clock, lane n from strobe n
  logic [DW-1:0] cap_r, cap_nxt;
  logic tog_r, tog_nxt;
  always_comb begin
    cap_nxt = cap_r;
    tog_nxt = tog_r;
    if (|i_byte_data_strobe) begin
      for (int b = 0; b < NB; b++) begin
        if (i_byte_data_strobe[b]) begin
          cap_nxt[8*b +: 8] = i_mem_data_bus[8*b +: 8];
        end
      end
      tog_nxt = ~tog_r;
    end
  end
  // link-side flops take reset asynchronously: the read clock only
  // runs inside bursts, so a synchronous reset would never reach them
  always_ff @(posedge i_rd_clk or posedge i_rst) begin
    if (i_rst) begin
      cap_r <= '0;
      tog_r <= 1'b0;
    end else begin
      cap_r <= cap_nxt;
      tog_r <= tog_nxt;
    end
  end

  // toggle crossing back to the system clock
  logic s1_r, s2_r, s3_r;
  logic [DW-1:0] rd_r, rd_nxt;
  logic rv_r, rv_nxt;
  always_comb begin
    rv_nxt = s2_r ^ s3_r;
    rd_nxt = rv_nxt ? cap_r : rd_r;
  end
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
      rd_r <= '0;
      rv_r <= 1'b0;
    end else if (i_ce) begin
      s1_r <= tog_r;
      s2_r <= s1_r;
      s3_r <= s2_r;
      rd_r <= rd_nxt;
      rv_r <= rv_nxt;
    end
  end
  assign o_rd_valid = rv_r;
  assign o_rd_data = rd_r;

  // checks
  property p_copy;
    @(posedge i_mclk) disable iff (i_rst)
      o_mem_addr_copy ==
        o_mem_addr_primary[ddrb_pkg::COPY_HI:ddrb_pkg::COPY_LO];
  endproperty
  a_copy: assert property (p_copy) else $error("copy mismatch");
  // only the self-refresh entry may select every row at once
  property p_one_cs;
    @(posedge i_mclk) disable iff (i_rst)
      ($countones(~o_row_select_n) <= 1) ||
        (o_row_select_n == '0 && o_row_clock_enable == '0 &&
         {o_row_strobe_n, o_col_strobe_n, o_write_enable_n} ==
           ddrb_pkg::CMD_REF);
  endproperty
  a_one_cs: assert property (p_one_cs) else $error("multi select");
  property p_cmd;
    @(posedge i_mclk) disable iff (i_rst)
      (st_r == ST_RUN && q_valid && !i_suspend && i_ce) |=>
        {o_row_strobe_n, o_col_strobe_n, o_write_enable_n} == $past(q_req.cmd);
  endproperty
  a_cmd: assert property (p_cmd) else $error("bad command");
  property p_nop;
    @(posedge i_mclk) disable iff (i_rst)
      (&o_row_select_n) |-> o_row_strobe_n && o_col_strobe_n;
  endproperty
  a_nop: assert property (p_nop) else $error("command unselected");
  property p_init;
    @(posedge i_mclk) disable iff (i_rst)
      !o_init_done |-> o_row_clock_enable == '0;
  endproperty
  a_init: assert property (p_init) else $error("cke during init");
  property p_sref;
    @(posedge i_mclk) disable iff (i_rst)
      o_self_refresh |-> o_row_clock_enable == '0;
  endproperty
  a_sref: assert property (p_sref) else $error("cke in sref");
  // data and strobe driven for exactly the one write-data cycle
  property p_wr;
    @(posedge i_mclk) disable iff (i_rst)
      (i_ce && st_r == ST_WDAT) |=>
        (o_mem_data_bus_oe == '1 && o_byte_data_strobe_oe == '1)
        ##1 (o_mem_data_bus_oe == '0 || !$past(i_ce));
  endproperty
  a_wr: assert property (p_wr) else $error("write drive");
  // data and mask stand still around the strobe pulse
  property p_wdata_hold;
    @(posedge i_mclk) disable iff (i_rst)
      (o_byte_data_strobe_oe != '0) |->
        ($stable(o_mem_data_bus) && $stable(o_byte_write_mask));
  endproperty
  a_wdata_hold: assert property (p_wdata_hold) else $error("eye moved");
  // complement always opposite to the true clock
  property p_clk_pair;
    @(posedge i_mclk) disable iff (i_rst)
      o_mem_diff_clock_out == ~o_mem_diff_clock_out_n;
  endproperty
  a_clk_pair: assert property (p_clk_pair) else $error("clock pair");
  property p_pd;
    @(posedge i_mclk) disable iff (i_rst)
      (i_ce && st_r == ST_RUN && !i_suspend && !q_valid) |=>
        o_row_clock_enable == ~$past(i_row_idle);
  endproperty
  a_pd: assert property (p_pd) else $error("power-down");
endmodule
`default_nettype wire

// file: ddrb_dimm_model.sv
// behavioural memory module pair on channel b
`timescale 1ns/10ps
`default_nettype none
module ddrb_dimm_model (
  input wire logic i_mclk,
  input wire logic [3:0] i_cs_n,
  input wire logic [2:0] i_cmd,
  input wire logic [1:0] i_bank,
  input wire logic [12:0] i_addr,
  input wire logic [63:0] i_dq,
  input wire logic [7:0] i_dq_oe,
  input wire logic [7:0] i_dm,
  input wire logic [7:0] i_dqs,
  input wire logic [7:0] i_dqs_oe,
  output logic o_rd_clk,
  output logic [63:0] o_dq,
  output logic [7:0] o_dqs
);
  logic [63:0] mem [int]; // words by bank and address
  logic [63:0] drv = 64'h0; // own data drive
  logic [7:0] sdrv = 8'h00; // own strobe drive
  logic [63:0] rd_word = 64'h0;
  int wkey = 0;
  bit wpend = 0;
  event go;
  // wire level: an enabled byte belongs to the controller
  always_comb begin
    for (int b = 0; b < 8; b++) begin
      o_dq[8*b+:8] = i_dq_oe[b] ? i_dq[8*b+:8] : drv[8*b+:8];
      o_dqs[b] = i_dqs_oe[b] ? i_dqs[b] : sdrv[b];
    end
  end
  // commands are sampled at the rising memory clock
  always @(posedge i_mclk) begin
    if (i_cs_n != 4'hf && i_cmd == 3'h4) begin
      wkey = {i_bank, i_addr};
      wpend = 1;
    end
    if (i_cs_n != 4'hf && i_cmd == 3'h5) begin
      rd_word = mem.exists({i_bank, i_addr}) ? mem[{i_bank, i_addr}] : 64'h0;
      -> go;
    end
  end
  // a byte lands only under its own strobe with its mask clear
  always @(negedge i_mclk) begin
    #1;
    if (wpend && i_dqs_oe != 8'h00) begin
      if (!mem.exists(wkey)) mem[wkey] = 64'h0;
      for (int b = 0; b < 8; b++)
        if (i_dqs[b] && !i_dm[b])
          mem[wkey][8*b+:8] = i_dq[8*b+:8];
      wpend = 0;
    end
  end
  // read beat: link clock runs only in the burst, strobe edge aligned
  initial begin
    o_rd_clk = 0;
    forever begin
      @(go);
      drv = rd_word;
      sdrv = 8'hff;
      repeat (4) begin
        #3 o_rd_clk = 1;
        #3 o_rd_clk = 0;
        // released bus shows the inverse, never the stale word
        drv = ~rd_word;
        sdrv = 8'h00;
      end
    end
  end
endmodule
`default_nettype wire

// file: ddr_channel_b_pin_interface_tb.sv
// self-checking bench for the channel b pin interface
`timescale 1ns/10ps
`default_nettype none
module ddr_channel_b_pin_interface_tb;
  localparam int DEPTH = 32;
  logic i_mclk = 0, i_rst = 0, i_req_valid = 0, i_suspend = 0;
  logic [3:0] i_row_idle = 4'h0;
  ddrb_pkg::ddrb_req_t i_req = '0, r = '0;
  logic ready, init_done, self_ref, rd_valid, rd_clk, ras_n, cas_n, we_n;
  logic [63:0] rd_data, dq_o, dq_i;
  logic [5:0] mclk_p, mclk_n;
  logic [3:0] cs_n, cke;
  logic [12:0] addr;
  logic [5:1] acopy;
  logic [1:0] bank;
  logic [7:0] dq_oe, dm, dqs_o, dqs_oe, dqs_i;
  int n_fail = 0, total_checks = 0, cyc = 0, n = 0, k = 0;
  logic [63:0] ref_m [int]; // reference memory
  ddrb_pkg::ddrb_cmd_t cl [4] = '{ddrb_pkg::CMD_MRS, ddrb_pkg::CMD_REF,
    ddrb_pkg::CMD_PRE, ddrb_pkg::CMD_ACT};
  ddrb_top #(.FIFO_DEPTH(DEPTH)) i_ddrb_top (.i_mclk(i_mclk),
    .i_rst(i_rst), .i_ce(1'b1), .i_rd_clk(rd_clk),
    .i_req_valid(i_req_valid), .o_req_ready(ready), .i_req(i_req),
    .i_suspend(i_suspend), .i_row_idle(i_row_idle),
    .o_init_done(init_done), .o_self_refresh(self_ref),
    .o_rd_valid(rd_valid), .o_rd_data(rd_data),
    .o_mem_diff_clock_out(mclk_p), .o_mem_diff_clock_out_n(mclk_n),
    .o_row_select_n(cs_n), .o_row_clock_enable(cke),
    .o_mem_addr_primary(addr), .o_mem_addr_copy(acopy),
    .o_bank_addr(bank), .o_row_strobe_n(ras_n), .o_col_strobe_n(cas_n),
    .o_write_enable_n(we_n), .i_mem_data_bus(dq_i),
    .o_mem_data_bus(dq_o), .o_mem_data_bus_oe(dq_oe),
    .o_byte_write_mask(dm), .i_byte_data_strobe(dqs_i),
    .o_byte_data_strobe(dqs_o), .o_byte_data_strobe_oe(dqs_oe));
  ddrb_dimm_model i_ddrb_dimm_model (.i_mclk(i_mclk), .i_cs_n(cs_n),
    .i_cmd({ras_n, cas_n, we_n}), .i_bank(bank), .i_addr(addr),
    .i_dq(dq_o), .i_dq_oe(dq_oe), .i_dm(dm), .i_dqs(dqs_o),
    .i_dqs_oe(dqs_oe), .o_rd_clk(rd_clk), .o_dq(dq_i), .o_dqs(dqs_i));
  initial forever #20 i_mclk = ~i_mclk;
  // hang guard, far above the expected hundred and fifty or so cycles
  always @(posedge i_mclk) begin
    cyc++;
    if (cyc > 20000) begin
      n_fail++;
      test_done();
    end
  end
  task automatic check(string what, logic [63:0] seen, logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task automatic test_done();
    $display("checks %0d fails %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // bounded wait at falling edges
  task automatic wait_for(ref logic s, input logic v);
    n = 0;
    while (s !== v && n < 60) begin
      @(negedge i_mclk);
      n++;
    end
  endtask
  task automatic rnd(ddrb_pkg::ddrb_cmd_t c);
    r.cmd = c;
    r.row = 2'($urandom);
    r.bank = 2'($urandom);
    r.addr = 13'($urandom);
    r.wdata = {$urandom, $urandom};
    r.wmask = 8'($urandom);
  endtask
  // push r, then compare the pins in the command's one cycle
  task automatic issue();
    i_req = r;
    i_req_valid = 1;
    wait_for(ready, 1'b1);
    @(negedge i_mclk);
    i_req_valid = 0;
    n = 0;
    while (cs_n === 4'hf && n < 20) begin
      @(negedge i_mclk);
      n++;
    end
    check("select", cs_n, 4'(~(4'h1 << r.row)));
    check("strobes", {ras_n, cas_n, we_n}, r.cmd);
    check("address", addr, r.addr);
    check("copy", acopy, r.addr[5:1]);
    check("bank", bank, r.bank);
    check("row cke", cke[r.row], 1'b1);
    k = {r.bank, r.addr};
    if (r.cmd == ddrb_pkg::CMD_WR) begin
      if (!ref_m.exists(k)) ref_m[k] = 64'h0;
      for (int b = 0; b < 8; b++)
        if (!r.wmask[b]) ref_m[k][8*b+:8] = r.wdata[8*b+:8];
    end
  endtask
  initial begin
    void'($urandom(73505));
    // a real rising edge, so the link-side flops see reset too
    #1 i_rst = 1;
    repeat (10) @(negedge i_mclk);
    i_rst = 0;
    repeat (ddrb_pkg::INIT_CYC - 1) @(negedge i_mclk);
    check("cke in init", cke, 4'h0);
    wait_for(init_done, 1'b1);
    check("cke after init", cke, 4'hf);
    @(posedge i_mclk);
    #5;
    check("clock true", mclk_p, 6'h3f);
    check("clock comp", mclk_n, 6'h00);
    @(negedge i_mclk);
    for (int i = 0; i < 8; i++) begin
      rnd(cl[i % 4]);
      issue();
    end
    // full write, masked overwrite, read back merged word
    repeat (4) begin
      rnd(ddrb_pkg::CMD_WR);
      r.wmask = 8'h00;
      issue();
      r.wdata = {$urandom, $urandom};
      r.wmask = 8'($urandom);
      issue();
      r.cmd = ddrb_pkg::CMD_RD;
      issue();
      wait_for(rd_valid, 1'b1);
      check("read data", rd_data, ref_m[k]);
    end
    i_suspend = 1;
    wait_for(self_ref, 1'b1);
    check("self refresh", self_ref, 1'b1);
    check("cke suspend", cke, 4'h0);
    // requests pile up while suspended until the fifo refuses
    rnd(ddrb_pkg::CMD_NOP);
    i_req = r;
    i_req_valid = 1;
    n = 0;
    while (ready === 1 && n < 40) begin
      @(negedge i_mclk);
      n++;
    end
    i_req_valid = 0;
    check("fifo fill", n, DEPTH);
    i_suspend = 0;
    wait_for(self_ref, 1'b0);
    repeat (40) @(negedge i_mclk);
    check("cke resume", cke, 4'hf);
    check("fifo empty", ready, 1'b1);
    check("drained", cs_n, 4'hf);
    i_row_idle = 4'h5;
    repeat (4) @(negedge i_mclk);
    check("power down", cke, 4'ha);
    i_row_idle = 4'h0;
    test_done();
  end
endmodule
`default_nettype wire
